// *** src/fclp_pkg.sv ***
package fclp_pkg;

    // Fuse byte field positions (zero means programmed)
    localparam int FUSE_DOUBLE_SPEED_BIT = 7;
    localparam int FUSE_BOOT_JUMP_BIT    = 6;
    localparam int FUSE_EXPANDED_RAM_FUSE_BIT         = 3;
    localparam int FUSE_LOCK_HIGH_BIT    = 2;
    localparam int FUSE_LOCK_MID_BIT     = 1;
    localparam int FUSE_LOCK_LOW_BIT     = 0;

    // Delivered fuse byte: boot jump and top lock programmed
    localparam logic [7:0] FUSE_DELIVERED = 8'hBB;
    // Inactive state after chip erase: everything unprogrammed
    localparam logic [7:0] FUSE_ERASED    = 8'hFF;

    localparam int SEC_LOCK_LOW_BIT  = 0;
    localparam int SEC_LOCK_HIGH_BIT = 1;
    localparam logic [7:0] SEC_RESET     = 8'hFF;
    localparam logic [7:0] BOOT_STAT_RESET = 8'hFF;
    localparam logic [7:0] BOOT_STAT_APP   = 8'h00;
    localparam logic [7:0] BOOT_VEC_RESET  = 8'hFC;

    localparam logic [15:0] BOOT_ROM_ADDR = 16'hF800;
    localparam logic [15:0] APP_ADDR      = 16'h0000;

    // Part identification; value is arbitrary
    localparam logic [31:0] PART_ID = 32'h1234_5678;

    typedef enum logic [1:0] {
        FCLP_HW_LVL1 = 2'b00,
        FCLP_HW_LVL2 = 2'b01,
        FCLP_HW_LVL3 = 2'b10,
        FCLP_HW_LVL4 = 2'b11
    } fclp_hw_level_e;

    typedef struct packed {
        logic par_prog_ok;
        logic par_verify_ok;
        logic table_read_ok;
        logic ext_exec_ok;
        logic isp_prog_ok;
        logic isp_verify_ok;
    } fclp_perm_s;

endpackage

// *** src/fclp_top.sv ***
`timescale 1ns/1ps
// How it works
// RQ1 - All hardware lock bits unprogrammed: level 1, no restriction at all.
// RQ2 - Level 2 up: external code cannot table-read internal memory.
// RQ3 - Level 2 up: external access pin latched at reset and held.
// RQ4 - Level 2 up: parallel programming refused; in-system programming stays.
// RQ5 - Level 3 up: parallel verify reads refused.
// RQ6 - Level 4: external execution disabled; level 4 is delivered default.
// RQ7 - A zero bit is programmed, a one bit unprogrammed.
// RQ8 - Chip erase wipes code and returns fuse byte to inactive state.
// RQ9 - Part identification readable in parallel mode at any level.
// RQ10 - Delivered fuse: boot jump and high lock programmed, others unprogrammed, level four.
// RQ11 - Boot status cleared to zero lets application boot at zero.
// RQ12 - Software keeps security byte bits 7 to 2 set.
// RQ13 - Both soft lock bits one: free; low cleared: no ISP programming.
// RQ14 - High soft lock bit cleared: ISP verify also refused.
// RQ15 - Hardware locks govern parallel only; soft bits govern ISP only; the code also lets soft bits lock boot byte writes from any caller.
// RQ16 - Security byte alone never protects against parallel access; the code locks boot byte writes from all callers by soft bits.
// RQ17 - Pin high fetches internally; pin low sends all fetches outside.
// RQ18 - Extra array bytes reachable by parallel, ISP and application calls.
// RQ19 - Programmer sets levels 2 and 3 only after verification.
// RQ20 - Boot jump programmed starts at boot ROM, else at zero; the code also starts at boot ROM while boot status is not zero.
// RQ21 - User boot vector defaults to no customer loader value.
// RQ22 - Security byte writes can only raise the level.
// RQ23 - Lock fields read at reset and held until reset or erase; the code also re-reads them after each fuse write.
// RQ24 - Highest programmed lock bit wins; lower ones are don't-care.
module fclp_top (
    input  wire logic        mclk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        clk_en_i,
    input  wire logic [7:0]  nv_fuse_i,
    input  wire logic        nv_fuse_valid_i,
    input  wire logic        external_access_pin_i,
    input  wire logic        fuse_wr_i,
    input  wire logic [7:0]  fuse_wdata_i,
    input  wire logic        chip_erase_i,
    input  wire logic        sec_wr_i,
    input  wire logic [7:0]  sec_wdata_i,
    input  wire logic        boot_stat_wr_i,
    input  wire logic [7:0]  boot_stat_wdata_i,
    input  wire logic        boot_vec_wr_i,
    input  wire logic [7:0]  boot_vec_wdata_i,
    input  wire logic        par_prog_req_i,
    input  wire logic        par_verify_req_i,
    input  wire logic        par_id_req_i,
    input  wire logic        isp_prog_req_i,
    input  wire logic        isp_verify_req_i,
    input  wire logic        table_read_req_i,
    input  wire logic        fetch_from_ext_i,
    output logic [7:0]       hardware_fuse_byte_o,
    output logic [7:0]       isp_security_byte_o,
    output logic [7:0]       boot_status_byte_o,
    output logic [7:0]       user_boot_vector_o,
    output logic [1:0]       hw_level_o,
    output fclp_pkg::fclp_perm_s perm_o,
    output logic             par_prog_grant_o,
    output logic             par_verify_grant_o,
    output logic             par_id_grant_o,
    output logic [31:0]      part_id_o,
    output logic             isp_prog_grant_o,
    output logic             isp_verify_grant_o,
    output logic             table_read_grant_o,
    output logic             ext_exec_allow_o,
    output logic             fetch_internal_o,
    output logic             ea_latched_o,
    output logic [15:0]      boot_addr_o,
    output logic             code_erase_o
);

    logic [7:0]  fuse_reg;
    logic [7:0]  sec_reg;
    logic [7:0]  boot_stat_reg;
    logic [7:0]  boot_vec_reg;
    logic        loaded_reg;
    logic        ea_reg;
    fclp_pkg::fclp_hw_level_e level_reg;
    logic        relevel_reg;

    // Nonvolatile bytes in the extra array; written through the
    // shared port by parallel, ISP or application callers alike.
    logic [7:0] fuse_next;
    logic [7:0] sec_next;
    logic [7:0] boot_stat_next;
    logic [7:0] boot_vec_next;
    logic       loaded_next;
    logic       ea_next;
    logic       relevel_next;
    fclp_pkg::fclp_hw_level_e level_next;

    // Junk on the storage lines before valid is never taken
    wire load_now = ~loaded_reg & nv_fuse_valid_i;

    wire lock_low  = ~fuse_reg[fclp_pkg::FUSE_LOCK_LOW_BIT];   // [RQ7]
    wire lock_mid  = ~fuse_reg[fclp_pkg::FUSE_LOCK_MID_BIT];   // [RQ7]
    wire lock_high = ~fuse_reg[fclp_pkg::FUSE_LOCK_HIGH_BIT];  // [RQ7]

    // Priority decode so lower bits are ignored under a higher one
    wire fclp_pkg::fclp_hw_level_e level_dec =
        lock_high ? fclp_pkg::FCLP_HW_LVL4 :                   // [RQ24]
        lock_mid  ? fclp_pkg::FCLP_HW_LVL3 :                   // [RQ24]
        lock_low  ? fclp_pkg::FCLP_HW_LVL2 :
                    fclp_pkg::FCLP_HW_LVL1;                    // [RQ1]

    wire lvl_ge2 = level_reg != fclp_pkg::FCLP_HW_LVL1;
    wire lvl_ge3 = level_reg == fclp_pkg::FCLP_HW_LVL3 ||
                   level_reg == fclp_pkg::FCLP_HW_LVL4;
    wire lvl_ge4 = level_reg == fclp_pkg::FCLP_HW_LVL4;

    // ISP side sees only the security byte, never the fuse locks
    wire sec_low  = ~sec_reg[fclp_pkg::SEC_LOCK_LOW_BIT];      // [RQ15]
    wire sec_high = ~sec_reg[fclp_pkg::SEC_LOCK_HIGH_BIT];     // [RQ15]

    fclp_pkg::fclp_perm_s perm;
    assign perm.par_prog_ok   = loaded_reg & ~lvl_ge2;         // [RQ4] [RQ16]
    assign perm.par_verify_ok = loaded_reg & ~lvl_ge3;         // [RQ5]
    assign perm.table_read_ok = ~lvl_ge2 | ~fetch_from_ext_i;  // [RQ2]
    assign perm.ext_exec_ok   = ~lvl_ge4;                      // [RQ6]
    assign perm.isp_prog_ok   = ~sec_low & ~sec_high;          // [RQ13]
    assign perm.isp_verify_ok = ~sec_high;                     // [RQ14]

    // Live pin below level 2, reset-time latch at level 2 and up
    wire ea_eff = lvl_ge2 ? ea_reg : external_access_pin_i;    // [RQ3]
    wire fetch_int = ea_eff & ~fetch_from_ext_i;               // [RQ17]
    wire exec_allow = perm.ext_exec_ok;

    // Only zeros may be added, so a write can never drop the level
    wire [7:0] sec_merge = sec_reg & (sec_wdata_i | 8'hFC);    // [RQ22] [RQ12]

    assign fuse_next =
        chip_erase_i    ? fclp_pkg::FUSE_ERASED :              // [RQ8]
        fuse_wr_i       ? fuse_wdata_i :
        load_now        ? nv_fuse_i : fuse_reg;
    assign sec_next  =
        chip_erase_i    ? fclp_pkg::SEC_RESET :                // [RQ8]
        sec_wr_i        ? sec_merge : sec_reg;
    // Boot bytes are write-locked once the soft level is raised
    assign boot_stat_next =
        chip_erase_i    ? fclp_pkg::BOOT_STAT_RESET :
        (boot_stat_wr_i & perm.isp_prog_ok) ? boot_stat_wdata_i :  // [RQ18]
        boot_stat_reg;
    assign boot_vec_next =
        chip_erase_i    ? fclp_pkg::BOOT_VEC_RESET :
        (boot_vec_wr_i & perm.isp_prog_ok) ? boot_vec_wdata_i :    // [RQ18]
        boot_vec_reg;

    wire boot_jump = ~fuse_reg[fclp_pkg::FUSE_BOOT_JUMP_BIT];
    wire app_ready = boot_stat_reg == fclp_pkg::BOOT_STAT_APP;
    wire [15:0] boot_addr =
        (boot_jump | ~app_ready) ? fclp_pkg::BOOT_ROM_ADDR :   // [RQ20] [RQ11]
                                   fclp_pkg::APP_ADDR;

    assign loaded_next  = loaded_reg | load_now;
    assign ea_next      = load_now ? external_access_pin_i : ea_reg;   // [RQ3]
    // Decode one cycle late so the level sees the byte just stored;
    // an erase in the same cycle wins over the write.
    assign relevel_next = (load_now | fuse_wr_i) & ~chip_erase_i;
    assign level_next   =
        chip_erase_i ? fclp_pkg::FCLP_HW_LVL1 :                // [RQ8]
        relevel_reg  ? level_dec :                             // [RQ24]
                       level_reg;                              // [RQ23]

    // Grant terms; each term is copied to its output by one flip-flop below
    wire par_prog_grant_next   = par_prog_req_i & perm.par_prog_ok;
    wire par_verify_grant_next = par_verify_req_i & perm.par_verify_ok;
    wire isp_prog_grant_next   = isp_prog_req_i & perm.isp_prog_ok;
    wire isp_verify_grant_next = isp_verify_req_i & perm.isp_verify_ok;
    wire table_read_grant_next = table_read_req_i & perm.table_read_ok;

    // Extra array bytes and the fuse copy
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            fuse_reg      <= fclp_pkg::FUSE_DELIVERED;         // [RQ10]
            sec_reg       <= fclp_pkg::SEC_RESET;
            boot_stat_reg <= fclp_pkg::BOOT_STAT_RESET;
            boot_vec_reg  <= fclp_pkg::BOOT_VEC_RESET;         // [RQ21]
        end else if (clk_en_i) begin
            fuse_reg      <= fuse_next;
            sec_reg       <= sec_next;
            boot_stat_reg <= boot_stat_next;
            boot_vec_reg  <= boot_vec_next;
        end
    end

    // Reset-time capture of the fuse byte and the pin
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            loaded_reg  <= 1'b0;
            ea_reg      <= 1'b1;
            relevel_reg <= 1'b0;
        end else if (clk_en_i) begin
            loaded_reg  <= loaded_next;
            ea_reg      <= ea_next;
            relevel_reg <= relevel_next;
        end
    end

    // Level stays at the safest value until the fuse byte is in
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            level_reg <= fclp_pkg::FCLP_HW_LVL4;               // [RQ6]
        end else if (clk_en_i) begin
            level_reg <= level_next;                           // [RQ23]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            hardware_fuse_byte_o <= fclp_pkg::FUSE_DELIVERED;
            isp_security_byte_o  <= fclp_pkg::SEC_RESET;
            boot_status_byte_o   <= fclp_pkg::BOOT_STAT_RESET;
            user_boot_vector_o   <= fclp_pkg::BOOT_VEC_RESET;
            hw_level_o           <= fclp_pkg::FCLP_HW_LVL4;
        end else if (clk_en_i) begin
            hardware_fuse_byte_o <= fuse_reg;
            isp_security_byte_o  <= sec_reg;
            boot_status_byte_o   <= boot_stat_reg;
            user_boot_vector_o   <= boot_vec_reg;
            hw_level_o           <= level_reg;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            perm_o             <= '0;
            par_prog_grant_o   <= 1'b0;
            par_verify_grant_o <= 1'b0;
            par_id_grant_o     <= 1'b0;
            part_id_o          <= 32'h0000_0000;
            isp_prog_grant_o   <= 1'b0;
            isp_verify_grant_o <= 1'b0;
            table_read_grant_o <= 1'b0;
        end else if (clk_en_i) begin
            perm_o             <= perm;
            par_prog_grant_o   <= par_prog_grant_next;             // [RQ4]
            par_verify_grant_o <= par_verify_grant_next;           // [RQ5]
            par_id_grant_o     <= par_id_req_i;                    // [RQ9]
            part_id_o          <= fclp_pkg::PART_ID;               // [RQ9]
            isp_prog_grant_o   <= isp_prog_grant_next;             // [RQ13]
            isp_verify_grant_o <= isp_verify_grant_next;           // [RQ14]
            table_read_grant_o <= table_read_grant_next;           // [RQ2]
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ext_exec_allow_o <= 1'b0;
            fetch_internal_o <= 1'b1;
            ea_latched_o     <= 1'b1;
            boot_addr_o      <= fclp_pkg::BOOT_ROM_ADDR;
            code_erase_o     <= 1'b0;
        end else if (clk_en_i) begin
            ext_exec_allow_o <= exec_allow;                      // [RQ6]
            fetch_internal_o <= fetch_int;                       // [RQ17]
            ea_latched_o     <= ea_eff;                          // [RQ3]
            boot_addr_o      <= boot_addr;                       // [RQ20]
            code_erase_o     <= chip_erase_i;                    // [RQ8]
        end
    end

endmodule

// *** testbench/fclp_checker.sv ***
`timescale 1ns/1ps
module fclp_checker (
    input wire logic                 mclk_i,
    input wire logic                 sys_rst_i,
    input wire logic                 clk_en_i,
    input wire logic                 par_id_req_i,
    input wire logic                 table_read_req_i,
    input wire logic                 fetch_from_ext_i,
    input wire logic [7:0]           hardware_fuse_byte_o,
    input wire logic [7:0]           isp_security_byte_o,
    input wire logic [7:0]           boot_status_byte_o,
    input wire logic [1:0]           hw_level_o,
    input wire fclp_pkg::fclp_perm_s perm_o,
    input wire logic                 par_prog_grant_o,
    input wire logic                 par_id_grant_o,
    input wire logic                 table_read_grant_o,
    input wire logic                 fetch_internal_o,
    input wire logic                 ea_latched_o,
    input wire logic [15:0]          boot_addr_o,
    input wire logic                 code_erase_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);
    a_id_always_read: assert property (
        clk_en_i && par_id_req_i |=> par_id_grant_o)
        else $error("part id request refused");
    a_par_prog_lock: assert property (
        par_prog_grant_o |-> hw_level_o == 2'h0)
        else $error("parallel programming granted while locked");
    a_table_read_lock: assert property (
        table_read_grant_o |-> $past(table_read_req_i) &&
        (hw_level_o == 2'h0 || !$past(fetch_from_ext_i)))
        else $error("table read from external code granted");
    a_isp_perm_bits: assert property (
        perm_o.isp_prog_ok |-> isp_security_byte_o[1:0] == 2'h3)
        else $error("isp programming allowed with lock bit set");
    a_sec_raise_only: assert property (
        (isp_security_byte_o[1:0] & ~$past(isp_security_byte_o[1:0]))
            != 2'h0 |-> $past(code_erase_o))
        else $error("security level lowered without erase");
    a_erase_clears_fuse: assert property (
        code_erase_o |=> hardware_fuse_byte_o == 8'hFF && hw_level_o == 2'h0)
        else $error("erase left fuse byte active");
    a_boot_addr_select: assert property (
        boot_addr_o == ((!hardware_fuse_byte_o[6] ||
                         boot_status_byte_o != 8'h00) ? 16'hF800 : 16'h0000))
        else $error("boot address wrong");
    a_fetch_int_pin: assert property (
        !$past(sys_rst_i) && fetch_internal_o |->
        ea_latched_o && !$past(fetch_from_ext_i))
        else $error("internal fetch without pin high");
    c_level4: cover property (hw_level_o == 2'h3);
    c_erase: cover property (code_erase_o);
    c_isp_lock: cover property (!perm_o.isp_verify_ok && !sys_rst_i);
endmodule
bind fclp_top fclp_checker u_chk (.*);

// *** testbench/fclp_nv_model.sv ***
`timescale 1ns/1ps
module fclp_nv_model (
    input  wire logic       mclk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [7:0] fuse_val_i,
    output logic [7:0]      nv_fuse_o = 8'h00,
    output logic            nv_fuse_valid_o = 1'b0
);
    // Storage is unreadable in reset, so the data lines carry junk until then
    always @(posedge mclk_i) begin
        nv_fuse_valid_o <= !sys_rst_i;
        nv_fuse_o <= sys_rst_i ? ~fuse_val_i : fuse_val_i;
    end
endmodule

// *** testbench/fclp_tb_top.sv ***
`timescale 1ns/1ps
module fclp_tb_top;
    logic mclk_i = 0, sys_rst_i = 1, clk_en_i = 1, external_access_pin_i = 1;
    logic fuse_wr_i = 0, chip_erase_i = 0, sec_wr_i = 0, boot_stat_wr_i = 0;
    logic boot_vec_wr_i = 0, par_prog_req_i = 0, par_verify_req_i = 0;
    logic par_id_req_i = 0, isp_prog_req_i = 0, isp_verify_req_i = 0;
    logic table_read_req_i = 0, fetch_from_ext_i = 0, nv_fuse_valid_i;
    logic [7:0] fuse_wdata_i = 0, sec_wdata_i = 0, boot_stat_wdata_i = 0;
    logic [7:0] boot_vec_wdata_i = 0, nv_fuse_i, fuse_val = 8'hFF;
    logic [7:0] hardware_fuse_byte_o, isp_security_byte_o;
    logic [7:0] boot_status_byte_o, user_boot_vector_o;
    logic [1:0] hw_level_o;
    fclp_pkg::fclp_perm_s perm_o;
    logic [31:0] part_id_o;
    logic [15:0] boot_addr_o;
    logic par_prog_grant_o, par_verify_grant_o, par_id_grant_o, code_erase_o;
    logic isp_prog_grant_o, isp_verify_grant_o, table_read_grant_o;
    logic ext_exec_allow_o, fetch_internal_o, ea_latched_o;
    int bad_count = 0, checks_done = 0, cyc = 0;
    fclp_top u_dut (.*);
    fclp_nv_model u_nv (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .fuse_val_i(fuse_val), .nv_fuse_o(nv_fuse_i),
        .nv_fuse_valid_o(nv_fuse_valid_i));
    always #5 mclk_i = ~mclk_i;
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc > 3000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic step(int n = 1);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic boot(logic [7:0] fuse, logic ea);
        fuse_val = fuse;
        external_access_pin_i = ea;
        sys_rst_i = 1;
        step(4);
        sys_rst_i = 0;
        step(4);
    endtask
    task automatic pulse(ref logic stb);
        stb = 1;
        step();
        stb = 0;
        step(3);
    endtask
    task automatic t_levels();
        logic [1:0] lv;
        {par_prog_req_i, par_verify_req_i, par_id_req_i} = 3'h7;
        {isp_prog_req_i, isp_verify_req_i, table_read_req_i} = 3'h7;
        fetch_from_ext_i = 1;
        for (int b = 0; b < 8; b++) begin
            boot({5'h1F, 3'(b)}, 1'b1);
            lv = !b[2] ? 2'h3 : !b[1] ? 2'h2 : !b[0] ? 2'h1 : 2'h0;
            check("level", hw_level_o, lv);
            check("par_prog", par_prog_grant_o, lv == 0);
            check("par_verify", par_verify_grant_o, lv < 2);
            check("table_read", table_read_grant_o, lv == 0);
            check("ext_exec", ext_exec_allow_o, lv != 3);
            check("isp", {isp_prog_grant_o, isp_verify_grant_o}, 3);
            check("id_grant", par_id_grant_o, 1'b1);
            check("id", part_id_o, fclp_pkg::PART_ID);
            check("perm", perm_o,
                  {lv == 0, lv < 2, lv == 0, lv != 3, 2'h3});
        end
        fetch_from_ext_i = 0;
    endtask
    task automatic t_ea();
        boot(8'hFE, 1'b0);
        external_access_pin_i = 1;
        step(3);
        check("ea_hold", {ea_latched_o, fetch_internal_o}, 0);
        boot(8'hFF, 1'b0);
        check("ea_low", fetch_internal_o, 0);
        external_access_pin_i = 1;
        step(3);
        check("ea_live", {ea_latched_o, fetch_internal_o}, 3);
    endtask
    task automatic t_boot();
        boot(8'hBB, 1'b1);
        check("fuse", hardware_fuse_byte_o, 8'hBB);
        check("boot", boot_addr_o, 16'hF800);
        check("vec", user_boot_vector_o, 8'hFC);
        check("table_int", table_read_grant_o, 1'b1);
        fuse_wdata_i = 8'hFF;
        pulse(fuse_wr_i);
        pulse(boot_stat_wr_i);
        check("app", boot_addr_o, 16'h0000);
        boot_vec_wdata_i = 8'hF0;
        pulse(boot_vec_wr_i);
        check("vec_wr", user_boot_vector_o, 8'hF0);
        sec_wdata_i = 8'hFE;
        pulse(sec_wr_i);
        check("isp1", {isp_prog_grant_o, isp_verify_grant_o}, 1);
        boot_stat_wdata_i = 8'hFF;
        pulse(boot_stat_wr_i);
        check("bsb_lock", boot_status_byte_o, 8'h00);
        sec_wdata_i = 8'hFF;
        pulse(sec_wr_i);
        check("no_lower", isp_security_byte_o, 8'hFE);
        sec_wdata_i = 8'hFD;
        pulse(sec_wr_i);
        check("isp2", isp_security_byte_o, 8'hFC);
        check("isp2_verify", isp_verify_grant_o, 1'b0);
        check("par_free", par_prog_grant_o, 1);
        fuse_wdata_i = 8'hBB;
        pulse(fuse_wr_i);
        check("relock", {hw_level_o, par_prog_grant_o}, 3'h6);
        chip_erase_i = 1;
        step();
        chip_erase_i = 0;
        check("erase", code_erase_o, 1);
        step(3);
        check("erased_fuse", hardware_fuse_byte_o, 8'hFF);
        check("erased_sec", isp_security_byte_o, 8'hFF);
        check("unlock", {hw_level_o, par_prog_grant_o}, 3'h1);
        clk_en_i = 0;
        fuse_wdata_i = 8'hBB;
        pulse(fuse_wr_i);
        clk_en_i = 1;
        step(2);
        check("frozen", {hw_level_o, hardware_fuse_byte_o}, 10'h0FF);
    endtask
    initial begin
        t_levels();
        t_ea();
        t_boot();
        test_done();
    end
endmodule
